// ===== core/obt_pkg.sv
// package for the octal bus transceiver with storage registers
package obt_pkg;
  // word width of each bus
  localparam int WIDTH = 8;
  // storage register reset value (documented part has none; a sim needs one)
  localparam logic [7:0] REG_RESET = 8'h00;
  // synchroniser reset: every pin at its idle level, so the low enable sits high
  localparam logic [21:0] SYNC_RESET = 22'h4_0000;
  // variant codes: inverting or straight outputs
  typedef enum logic [1:0]
  {
    VAR_STRAIGHT = 2'b01,
    VAR_INVERT = 2'b10
  } obt_variant_t;
  // one three-state bus driver
  typedef struct packed
  {
    logic [7:0] data;
    logic oe;
  } obt_drive_t;
endpackage

// ===== core/obt_top.sv
// octal bus transceiver with per-direction storage registers
// Function
// - move bytes between buses a and b
// - capture clock rises load register from bus
// - select low live, high stored data
// - select change gives no output glitch
// - inverting variant drives complement
// - straight variant drives data unchanged
// - enables gate drivers; isolation when both off
// - a-to-b enabled, live: b follows a
// - b-to-a enabled, live: a follows b
// - a-to-b stored: b shows a register
// - b-to-a stored: a shows b register
// - both stored: both registers driven together
// - a driving b loads both registers
// - b driving a loads both registers
// - both live enabled: each bus echoes the other bus's sampled value
module obt_top #(
  parameter obt_pkg::obt_variant_t VARIANT = obt_pkg::VAR_STRAIGHT
) (
  // system clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // capture clocks from pins
  input wire logic a_capture_clock,
  input wire logic b_capture_clock,
  // controls from pins
  input wire logic a_to_b_drive_enable,
  input wire logic b_to_a_drive_enable_n,
  input wire logic a_to_b_source_select,
  input wire logic b_to_a_source_select,
  // bus a pin split
  input wire logic [7:0] bus_a_in,
  output logic [7:0] bus_a_out,
  output logic bus_a_oe,
  // bus b pin split
  input wire logic [7:0] bus_b_in,
  output logic [7:0] bus_b_out,
  output logic bus_b_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; every pin passes them before use
  // limitation: a data or control pin change reaches the outputs three clocks later (a capture rise, four), and a
  // capture pulse must stay one clock high and one low to be seen
  logic [21:0] sy1_r, sy1_nxt, sy2_r, sy2_nxt;
  // stage one samples pins, stage two samples stage one only
  always_comb
  begin
    sy1_nxt = {a_capture_clock, b_capture_clock, a_to_b_drive_enable,
               b_to_a_drive_enable_n, a_to_b_source_select,
               b_to_a_source_select, bus_a_in, bus_b_in};
    sy2_nxt = sy1_r;
  end
  // both stages reset to idle pin levels: an all-zero reset would read as an
  // active low enable and drive bus a for two clocks after release
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      sy1_r <= obt_pkg::SYNC_RESET;
      sy2_r <= obt_pkg::SYNC_RESET;
    end
    else
    begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
    end
  end
  // named views of the synchronised pins
  logic cka, ckb, en_ab, en_ba_n, sel_ab, sel_ba;
  logic [7:0] a_s, b_s;
  assign {cka, ckb, en_ab, en_ba_n, sel_ab, sel_ba, a_s, b_s} = sy2_r;

  ////////////////////////////////////////////////////////////////////////////
  // capture edge detect and storage registers
  logic cka_d_r, cka_d_nxt, ckb_d_r, ckb_d_nxt;
  logic [7:0] reg_a_r, reg_a_nxt, reg_b_r, reg_b_nxt;
  logic rise_a, rise_b;
  // one-clock rise strobes; history resets low like the idle capture pins
  assign rise_a = cka & ~cka_d_r;
  assign rise_b = ckb & ~ckb_d_r;
  // loads ignore selects and enables; bus value is whatever is on the wire,
  // so a driven bus copies into the far register too
  // a rise and its data cross the synchroniser together, so no skew between them
  always_comb
  begin
    cka_d_nxt = cka;
    ckb_d_nxt = ckb;
    reg_a_nxt = rise_a ? a_s : reg_a_r;
    reg_b_nxt = rise_b ? b_s : reg_b_r;
  end
  // edge history and storage registers
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cka_d_r <= 1'b0;
      ckb_d_r <= 1'b0;
      reg_a_r <= obt_pkg::REG_RESET;
      reg_b_r <= obt_pkg::REG_RESET;
    end
    else
    begin
      cka_d_r <= cka_d_nxt;
      ckb_d_r <= ckb_d_nxt;
      reg_a_r <= reg_a_nxt;
      reg_b_r <= reg_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output path: mux, polarity, registered so a select change never glitches
  obt_pkg::obt_drive_t drv_a_r, drv_a_nxt, drv_b_r, drv_b_nxt;
  // polarity flag, fixed for each instance by the variant parameter
  logic inv;
  assign inv = (VARIANT == obt_pkg::VAR_INVERT);
  // next drive values: source mux, then polarity, then enables
  always_comb
  begin
    // live bus when select low, stored word when high
    drv_b_nxt.data = sel_ab ? reg_a_r : a_s;
    drv_a_nxt.data = sel_ba ? reg_b_r : b_s;
    // polarity by variant
    if (inv)
    begin
      drv_b_nxt.data = ~drv_b_nxt.data;
      drv_a_nxt.data = ~drv_a_nxt.data;
    end
    // straight variant leaves data as is
    drv_b_nxt.oe = en_ab;
    drv_a_nxt.oe = ~en_ba_n;
  end
  // flops remove mux decoding glitches at the cost of latency
  // trade-off: one more clock on every path, but no pin-to-pin combinational path
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      drv_a_r <= '0;
      drv_b_r <= '0;
    end
    else
    begin
      drv_a_r <= drv_a_nxt;
      drv_b_r <= drv_b_nxt;
    end
  end
  // split driver ports
  // both live and enabled: each bus echoes the other bus's sampled value
  assign bus_a_out = drv_a_r.data;
  assign bus_a_oe = drv_a_r.oe;
  assign bus_b_out = drv_b_r.data;
  assign bus_b_oe = drv_b_r.oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks: all sample the synchronised view, one clock ahead of the outputs
  // isolation: neither bus driven one clock after both enables go idle
  a_iso_both: assert property (@(posedge clk_sys) disable iff (reset)
    (!en_ab && en_ba_n) |=> (!bus_a_oe && !bus_b_oe))
    else $error("isolation not kept");
  // b drive off whenever its high enable is low
  a_b_off: assert property (@(posedge clk_sys) disable iff (reset)
    !en_ab |=> !bus_b_oe)
    else $error("b driven while disabled");
  // a drive off whenever its low enable is high
  a_a_off: assert property (@(posedge clk_sys) disable iff (reset)
    en_ba_n |=> !bus_a_oe)
    else $error("a driven while disabled");
  // live a to b, complemented in the inverting variant
  a_live_ab: assert property (@(posedge clk_sys) disable iff (reset)
    (en_ab && !sel_ab) |=> (bus_b_out == (inv ? ~$past(a_s) : $past(a_s))))
    else $error("b not live from a");
  // live b to a
  a_live_ba: assert property (@(posedge clk_sys) disable iff (reset)
    (!en_ba_n && !sel_ba) |=> (bus_a_out == (inv ? ~$past(b_s) : $past(b_s))))
    else $error("a not live from b");
  // stored a register onto bus b
  a_stored_ab: assert property (@(posedge clk_sys) disable iff (reset)
    (en_ab && sel_ab) |=> (bus_b_oe && bus_b_out == (inv ? ~$past(reg_a_r) : $past(reg_a_r))))
    else $error("b not from a register");
  // stored b register onto bus a
  a_stored_ba: assert property (@(posedge clk_sys) disable iff (reset)
    (!en_ba_n && sel_ba) |=> (bus_a_oe &&
    bus_a_out == (inv ? ~$past(reg_b_r) : $past(reg_b_r))))
    else $error("a not from b register");
  // both stored words driven at once
  a_both_stored: assert property (@(posedge clk_sys) disable iff (reset)
    (en_ab && sel_ab && !en_ba_n && sel_ba) |=> (bus_a_oe && bus_b_oe &&
    bus_a_out == (inv ? ~$past(reg_b_r) : $past(reg_b_r)) &&
    bus_b_out == (inv ? ~$past(reg_a_r) : $past(reg_a_r))))
    else $error("both stored words not driven");
  // a register loads on a capture rise, whatever drives bus a
  a_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    (cka && !$past(cka)) |=> (reg_a_r == $past(a_s)))
    else $error("a register missed load");
  // b register loads on a capture rise, whatever drives bus b
  a_load_b: assert property (@(posedge clk_sys) disable iff (reset)
    (ckb && !$past(ckb)) |=> (reg_b_r == $past(b_s)))
    else $error("b register missed load");
  // a register holds between rises
  a_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    !(cka && !$past(cka)) |=> $stable(reg_a_r))
    else $error("a register changed without edge");
  // b register holds between rises
  a_hold_b: assert property (@(posedge clk_sys) disable iff (reset)
    !(ckb && !$past(ckb)) |=> $stable(reg_b_r))
    else $error("b register changed without edge");
  // b drive turns on one clock after its enable rises
  a_oe_follow: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(en_ab) |=> (bus_b_oe && !$past(bus_b_oe)))
    else $error("b enable late");
  // a drive turns on one clock after its low enable falls
  a_oe_ba_follow: assert property (@(posedge clk_sys) disable iff (reset)
    $fell(en_ba_n) |=> (bus_a_oe && !$past(bus_a_oe)))
    else $error("a enable late");

  // each cover marks a scenario the bench must reach
  c_both_stored: cover property (@(posedge clk_sys) bus_a_oe && bus_b_oe && sel_ab && sel_ba);
  c_load_both: cover property (@(posedge clk_sys) rise_a && rise_b);
  c_iso: cover property (@(posedge clk_sys) !bus_a_oe && !bus_b_oe);
  c_live_ab: cover property (@(posedge clk_sys) bus_b_oe && en_ab && !sel_ab);
  c_feedback: cover property (@(posedge clk_sys) bus_a_oe && bus_b_oe && !sel_ab && !sel_ba);
endmodule // obt_top

// ===== tb/obt_bus_peer.sv
// far-side bus model: resolves both shared buses from every driver
module obt_bus_peer (
  // clock
  input wire logic clk_sys,
  // drivers: device side and far side
  input wire obt_pkg::obt_drive_t dev_a,
  input wire obt_pkg::obt_drive_t dev_b,
  input wire obt_pkg::obt_drive_t far_a,
  input wire obt_pkg::obt_drive_t far_b,
  // resolved levels
  output logic [7:0] wire_a,
  output logic [7:0] wire_b
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_a = 8'h00; // bus a one cycle ago
  logic [7:0] last_b = 8'h00; // bus b one cycle ago
  // a clash is unknown; a floating bus toggles so stale data never passes
  function automatic logic [7:0] res(obt_pkg::obt_drive_t d, obt_pkg::obt_drive_t f,
    logic [7:0] last);
    if (d.oe && f.oe && d.data !== f.data) return 8'hxx;
    if (d.oe) return d.data;
    if (f.oe) return f.data;
    return ~last;
  endfunction
  // device output fed back to its own input through the wire
  always_comb wire_a = res(dev_a, far_a, last_a);
  always_comb wire_b = res(dev_b, far_b, last_b);
  // remember last levels
  always @(posedge clk_sys)
  begin
    last_a <= wire_a;
    last_b <= wire_b;
  end
endmodule // obt_bus_peer

// ===== tb/obt_top_bench.sv
// self-checking bench for the octal bus transceiver
module obt_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic cab = 1'b0; // capture clocks
  logic cba = 1'b0;
  logic en_ab = 1'b0; // drive controls
  logic en_ba_n = 1'b1;
  logic sel_ab = 1'b0;
  logic sel_ba = 1'b0;
  obt_pkg::obt_drive_t far_a = '0; // far-side drivers
  obt_pkg::obt_drive_t far_b = '0;
  logic [7:0] ao, bo, wa, wb;
  logic aoe, boe;
  logic [7:0] ai, bi; // inverting twin outputs, observed only
  logic aie, bie;
  int fails = 0;
  int check_count = 0;
  always #2 clk_sys = ~clk_sys;
  obt_top dut (.clk_sys(clk_sys), .reset(reset), .a_capture_clock(cab), .b_capture_clock(cba),
    .a_to_b_drive_enable(en_ab), .b_to_a_drive_enable_n(en_ba_n),
    .a_to_b_source_select(sel_ab), .b_to_a_source_select(sel_ba), .bus_a_in(wa),
    .bus_a_out(ao), .bus_a_oe(aoe), .bus_b_in(wb), .bus_b_out(bo), .bus_b_oe(boe));
  obt_bus_peer peer (.clk_sys(clk_sys), .dev_a({ao, aoe}), .dev_b({bo, boe}),
    .far_a(far_a), .far_b(far_b), .wire_a(wa), .wire_b(wb));
  // inverting twin sees the same pins and buses but drives nothing
  obt_top #(.VARIANT(obt_pkg::VAR_INVERT)) dut_inv (.clk_sys(clk_sys), .reset(reset),
    .a_capture_clock(cab), .b_capture_clock(cba), .a_to_b_drive_enable(en_ab),
    .b_to_a_drive_enable_n(en_ba_n), .a_to_b_source_select(sel_ab),
    .b_to_a_source_select(sel_ba), .bus_a_in(wa), .bus_a_out(ai), .bus_a_oe(aie),
    .bus_b_in(wb), .bus_b_out(bi), .bus_b_oe(bie));
  //////////////////////////////////////////////////
  // inputs move 1 ns after the edge, clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] want);
    check_count++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // pulses long enough for the two-flop pin sampler
  task automatic pulse(input logic a, input logic b);
    cab = a;
    cba = b;
    step(4);
    cab = 1'b0;
    cba = 1'b0;
    step(4);
  endtask
  //////////////////////////////////////////////////
  // watchdog: the whole sequence needs under 200 cycles
  initial
  begin
    repeat (2000) @(posedge clk_sys);
    fails++;
    test_done();
  end
  // main sequence
  initial
  begin
    step(6);
    reset = 1'b0;
    step(2);
    chk({7'h00, aoe, boe}, 9'h000);
    far_a = {8'h5A, 1'b1};
    en_ab = 1'b1;
    step(8);
    chk({boe, bo}, 9'h15A);
    chk({bie, bi}, 9'h1A5);
    pulse(1'b1, 1'b0);
    far_a.data = 8'h3C;
    sel_ab = 1'b1;
    step(8);
    chk({boe, bo}, 9'h15A);
    sel_ab = 1'b0;
    step(8);
    chk({boe, bo}, 9'h13C);
    pulse(1'b1, 1'b1); // select low: both together is allowed
    far_a.oe = 1'b0;
    en_ab = 1'b0;
    step(4);
    far_b = {8'hC3, 1'b1};
    en_ba_n = 1'b0;
    sel_ba = 1'b1;
    step(8);
    chk({aoe, ao}, 9'h13C);
    sel_ba = 1'b0;
    step(8);
    chk({aoe, ao}, 9'h1C3);
    pulse(1'b0, 1'b1);
    far_b.data = 8'h99;
    sel_ba = 1'b1;
    step(8);
    chk({aoe, ao}, 9'h1C3);
    chk({aie, ai}, 9'h13C);
    far_b.oe = 1'b0;
    en_ab = 1'b1;
    sel_ab = 1'b1;
    step(8);
    chk({wa, wb[7]}, {8'hC3, 1'b0});
    chk({1'b0, wb}, 9'h03C);
    sel_ab = 1'b0;
    step(8);
    sel_ba = 1'b0;
    step(20);
    chk({wa, wb[0]}, {8'hC3, 1'b1});
    chk({1'b0, wb}, 9'h0C3);
    test_done();
  end
endmodule // obt_top_bench
